// [logic/tws_ctrl.sv]
// Three-wire serial transfer control with AXI4-Lite register access
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tws_ctrl
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [tws_pkg::TWS_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [tws_pkg::TWS_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SHIFT_CLOCK_PIN_I,
   output logic SHIFT_CLOCK_PIN_O,
   output logic SHIFT_CLOCK_PIN_OE_N,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_OUT_PIN,
   output logic TRANSFER_DONE_IRQ
);
   import tws_pkg::*;

   // Bit reversal for LSB-first loading and reading
   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = d[7-i];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   tws_mode_s mode_ff; // Software mode bits
   logic [15:0] div_ff; // Half period in CLK cycles
   logic aw_ok_ff; // Write address held
   logic [TWS_ADDR_W-1:0] aw_addr_ff;
   logic w_ok_ff; // Write data held
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_wr; // Both write halves present
   logic ar_hs; // Read address taken
   logic wr_data; // Shift register written
   logic rd_data; // Shift register read
   logic sck_m_ff; // Pin synchronisers
   logic sck_s_ff;
   logic sck_d_ff; // Previous synced level for edges
   logic si_m_ff;
   logic si_s_ff;
   logic ext_rise;
   logic ext_fall;
   tws_state_e state_ff;
   logic [2:0] cnt_ff; // Rising edges seen in this byte
   logic [15:0] div_cnt_ff;
   logic sck_ff; // Internal shift clock level
   logic tick; // Half period elapsed
   logic rise; // Shift clock rising edge in use
   logic fall;
   logic tx_act_ff; // Direction taken part at start
   logic rx_act_ff;
   logic tx_live;
   logic rx_live;
   logic rx_en_d_ff; // Previous receive enable
   logic start; // Transfer start request
   logic [7:0] sr_ff; // Shift register, next bit out always at top
   logic order_ff; // Order captured at load and again at each start
   logic so_ff;
   logic done_ff; // One-cycle completion pulse
   logic done_sticky_ff; // Status copy of completion
   logic stat_rd; // Status read clears sticky flag
   logic [15:0] reload;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   // Address and data are taken independently, then written together
   assign S_AXI_AWREADY = !aw_ok_ff && !bvalid_ff;
   assign S_AXI_WREADY = !w_ok_ff && !bvalid_ff;
   assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = !rvalid_ff;
   assign ar_hs = S_AXI_ARVALID && !rvalid_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign wr_data = do_wr && (aw_addr_ff == TWS_OFF_DATA) && w_strb_ff[0];
   assign rd_data = ar_hs && (S_AXI_ARADDR == TWS_OFF_DATA);
   assign stat_rd = ar_hs && (S_AXI_ARADDR == TWS_OFF_STAT);

   // Write address and data holding
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         aw_ok_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_ok_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end
      else if (do_wr)
      begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_ok_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_ok_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA;
            w_strb_ff <= S_AXI_WSTRB;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= TWS_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_ff <= 1'b1;
         if (aw_addr_ff == TWS_OFF_MODE || aw_addr_ff == TWS_OFF_DATA)
            bresp_ff <= TWS_RESP_OKAY;
         else if (aw_addr_ff == TWS_OFF_STAT || aw_addr_ff == TWS_OFF_DIV)
            bresp_ff <= TWS_RESP_OKAY;
         else
            bresp_ff <= TWS_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   // Mode and divider registers, byte strobes honoured
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         mode_ff <= TWS_MODE_RST;
         div_ff <= TWS_DIV_RST;
      end
      else if (do_wr)
      begin
         if (aw_addr_ff == TWS_OFF_MODE && w_strb_ff[0])
            mode_ff <= tws_mode_s'(w_data_ff[3:0]);
         else if (aw_addr_ff == TWS_OFF_DIV)
         begin
            if (w_strb_ff[0])
               div_ff[7:0] <= w_data_ff[7:0];
            if (w_strb_ff[1])
               div_ff[15:8] <= w_data_ff[15:8];
         end
      end
   end

   // Read path, answer one cycle after address is taken
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= TWS_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff <= TWS_RESP_OKAY;
         rdata_ff <= '0;
         if (S_AXI_ARADDR == TWS_OFF_MODE)
            rdata_ff[3:0] <= mode_ff;
         else if (S_AXI_ARADDR == TWS_OFF_DATA)
            rdata_ff[7:0] <= order_ff ? rev8(sr_ff) : sr_ff;
         else if (S_AXI_ARADDR == TWS_OFF_STAT)
         begin
            rdata_ff[TWS_STAT_BUSY] <= (state_ff != TWS_IDLE);
            rdata_ff[TWS_STAT_DONE] <= done_sticky_ff;
         end
         else if (S_AXI_ARADDR == TWS_OFF_DIV)
            rdata_ff[15:0] <= div_ff;
         else
            rresp_ff <= TWS_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
      begin
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and external edge detection

   // Two flops per pin; edges come from the second and a third
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sck_m_ff <= TWS_LINE_IDLE;
         sck_s_ff <= TWS_LINE_IDLE;
         sck_d_ff <= TWS_LINE_IDLE;
         si_m_ff <= 1'b0;
         si_s_ff <= 1'b0;
      end
      else
      begin
         sck_m_ff <= SHIFT_CLOCK_PIN_I;
         sck_s_ff <= sck_m_ff;
         sck_d_ff <= sck_s_ff;
         si_m_ff <= SERIAL_IN_PIN;
         si_s_ff <= si_m_ff;
      end
   end

   assign ext_rise = sck_s_ff && !sck_d_ff;
   assign ext_fall = !sck_s_ff && sck_d_ff;

   ////////////////////////////////////////////////////////////////////////
   // Transfer control

   // Directions still running; clearing an enable drops only that one
   assign tx_live = tx_act_ff && mode_ff.tx_enable_bit;
   assign rx_live = rx_act_ff && mode_ff.rx_enable_bit;

   // Start sources: data write with tx on, rx enable rise, data read with rx on
   assign start = (wr_data && mode_ff.tx_enable_bit)
      || (mode_ff.rx_enable_bit && !rx_en_d_ff)
      || (rd_data && mode_ff.rx_enable_bit)
      ;

   // Internal clock divider; zero behaves as one
   assign reload = (div_ff == 16'h0000) ? 16'h0000 : div_ff - 16'h0001;
   assign tick = (state_ff != TWS_IDLE) && mode_ff.int_clk && (div_cnt_ff == 16'h0000);

   // Edges seen only while a transfer runs; earlier edges do nothing
   assign rise = (state_ff != TWS_IDLE)
      && (mode_ff.int_clk ? (tick && !sck_ff) : ext_rise);
   assign fall = (state_ff == TWS_RUN)
      && (mode_ff.int_clk ? (tick && sck_ff) : ext_fall);

   // Enable edge tracker
   always_ff @(posedge CLK)
   begin
      if (RST)
         rx_en_d_ff <= 1'b0;
      else
         rx_en_d_ff <= mode_ff.rx_enable_bit;
   end

   // Transfer state, bit count and active directions
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_ff <= TWS_IDLE;
         cnt_ff <= '0;
         tx_act_ff <= 1'b0;
         rx_act_ff <= 1'b0;
      end
      else if (start)
      begin
         state_ff <= TWS_RUN;
         cnt_ff <= '0;
         tx_act_ff <= mode_ff.tx_enable_bit;
         rx_act_ff <= mode_ff.rx_enable_bit;
      end
      else if (!mode_ff.tx_enable_bit && !mode_ff.rx_enable_bit)
      begin
         // Both off: counter resynchronises to next byte
         cnt_ff <= '0;
         if (state_ff == TWS_RUN && mode_ff.int_clk && !sck_ff)
            state_ff <= TWS_STOP;
         else if (state_ff == TWS_STOP && !rise)
            state_ff <= TWS_STOP;
         else
            state_ff <= TWS_IDLE;
      end
      else
      begin
         case (state_ff)
            TWS_RUN:
            begin
               if (!tx_live && !rx_live)
               begin
                  // Last live direction dropped
                  if (mode_ff.int_clk && !sck_ff)
                     state_ff <= TWS_STOP;
                  else
                     state_ff <= TWS_IDLE;
               end
               else if (rise)
               begin
                  cnt_ff <= cnt_ff + 3'h1;
                  if (cnt_ff == TWS_LAST_BIT)
                     state_ff <= TWS_IDLE;
               end
            end
            TWS_STOP:
            begin
               // Abort lands on the rising edge, with no count
               if (rise)
                  state_ff <= TWS_IDLE;
            end
            default:
            begin
               state_ff <= TWS_IDLE;
            end
         endcase
      end
   end

   // Internal shift clock; idles high and starts high
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sck_ff <= TWS_LINE_IDLE;
         div_cnt_ff <= '0;
      end
      else if (start || state_ff == TWS_IDLE)
      begin
         // First fall comes one half period after start, within one period
         sck_ff <= TWS_LINE_IDLE;
         div_cnt_ff <= reload;
      end
      else if (tick)
      begin
         div_cnt_ff <= reload;
         // Stop high on the eighth rise or on an abort's rise
         if (!sck_ff)
            sck_ff <= 1'b1;
         else if (fall && (tx_live || rx_live))
            sck_ff <= 1'b0;
         // No fall once every direction is off, so an abort leaves no stray pulse
      end
      else
      begin
         div_cnt_ff <= div_cnt_ff - 16'h0001;
      end
   end

   // Shift register: load in stored order, sample input on rise
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sr_ff <= '0;
         order_ff <= 1'b0;
      end
      else if (wr_data)
      begin
         // Order applied now persists for this byte
         sr_ff <= mode_ff.bit_order_select ? rev8(w_data_ff[7:0]) : w_data_ff[7:0];
         order_ff <= mode_ff.bit_order_select;
      end
      else if (rise && state_ff == TWS_RUN && (tx_live || rx_live))
      begin
         // Input shifts in for tx-only too; content is the sampled input even if rx is off
         sr_ff <= {sr_ff[6:0], si_s_ff};
      end
      else if (start)
      begin
         order_ff <= mode_ff.bit_order_select;
      end
   end

   // Serial output: high while tx disabled, next bit on each fall
   always_ff @(posedge CLK)
   begin
      if (RST)
         so_ff <= TWS_LINE_IDLE;
      else if (!mode_ff.tx_enable_bit)
         so_ff <= TWS_LINE_IDLE;
      else if (fall && tx_live)
         so_ff <= sr_ff[7];
   end

   // Completion pulse on eighth rise; aborts never reach it
   always_ff @(posedge CLK)
   begin
      if (RST)
         done_ff <= 1'b0;
      else
         done_ff <= !start && rise && state_ff == TWS_RUN && (tx_live || rx_live)
            && cnt_ff == TWS_LAST_BIT;
   end

   // Status copy of completion; a new pulse beats the read clear
   always_ff @(posedge CLK)
   begin
      if (RST)
         done_sticky_ff <= 1'b0;
      else if (done_ff)
         done_sticky_ff <= 1'b1;
      else if (stat_rd)
         done_sticky_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins

   // Clock driven only in internal mode; enable low means driving
   assign SHIFT_CLOCK_PIN_O = sck_ff;
   assign SHIFT_CLOCK_PIN_OE_N = !mode_ff.int_clk;
   assign SERIAL_OUT_PIN = so_ff;
   assign TRANSFER_DONE_IRQ = done_ff;

endmodule // tws_ctrl

// [logic/tws_pkg.sv]
// Constants, types and field layout of the three-wire serial transfer control
package tws_pkg;

   // Register byte offsets
   localparam int unsigned TWS_ADDR_W = 4;
   localparam logic [3:0] TWS_OFF_MODE = 4'h0; // Mode bits
   localparam logic [3:0] TWS_OFF_DATA = 4'h4; // Shift register
   localparam logic [3:0] TWS_OFF_STAT = 4'h8; // Busy and done
   localparam logic [3:0] TWS_OFF_DIV = 4'hc; // Half period of shift clock

   // Field positions
   localparam int unsigned TWS_STAT_BUSY = 0;
   localparam int unsigned TWS_STAT_DONE = 1;

   // Values after reset, and last bit index
   localparam logic [15:0] TWS_DIV_RST = 16'h0004;
   localparam logic TWS_LINE_IDLE = 1'b1; // Idle level of clock and data out
   localparam logic [2:0] TWS_LAST_BIT = 3'h7; // Index of eighth bit

   // Bus answers
   localparam logic [1:0] TWS_RESP_OKAY = 2'h0;
   localparam logic [1:0] TWS_RESP_SLVERR = 2'h2;

   // Mode register, low bits of word
   typedef struct packed {
      logic int_clk; // Bit 3: drive shift clock ourselves
      logic bit_order_select; // Bit 2: 1 = LSB first
      logic rx_enable_bit; // Bit 1
      logic tx_enable_bit; // Bit 0
   } tws_mode_s;
   localparam tws_mode_s TWS_MODE_RST = '0;

   // Transfer state
   typedef enum logic [1:0] {
      TWS_IDLE = 2'b00,
      TWS_RUN = 2'b01,
      TWS_STOP = 2'b10 // Abort pending, waiting for clock rise
   } tws_state_e;

endpackage

// [testbench/tws_ctrl_monitor.sv]
// Port checks for the serial transfer control
`timescale 1ns/1ps
module tws_ctrl_monitor
   import tws_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [tws_pkg::TWS_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic SHIFT_CLOCK_PIN_O,
   input wire logic SHIFT_CLOCK_PIN_OE_N,
   input wire logic SERIAL_OUT_PIN,
   input wire logic TRANSFER_DONE_IRQ
);
   logic aw_h_ff; // Address half held
   logic w_h_ff; // Data half held
   logic [TWS_ADDR_W-1:0] addr_ff; // Held address
   logic [3:0] data_ff; // Held low data bits
   logic strb0_ff; // Held strobe of the low byte
   logic pend_ff; // Mode write lands at the next edge
   tws_mode_s pend_val_ff;
   tws_mode_s mode_ff; // Shadow of the mode bits
   logic aw_now;
   logic w_now;
   logic wr_done; // Halves pair this edge; write lands one edge later
   logic [TWS_ADDR_W-1:0] cur_addr;
   assign aw_now = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_now = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_done = (aw_now || aw_h_ff) && (w_now || w_h_ff);
   assign cur_addr = aw_now ? S_AXI_AWADDR : addr_ff;
   ////////////////////////////////////////////////////////////////////////////////
   // Halves may arrive in either order, so hold each until paired
   always_ff @(posedge CLK)
   begin
      aw_h_ff <= !RST && (aw_now || aw_h_ff) && !wr_done;
      w_h_ff <= !RST && (w_now || w_h_ff) && !wr_done;
      if (aw_now) addr_ff <= S_AXI_AWADDR;
      if (w_now) data_ff <= S_AXI_WDATA[3:0];
      if (w_now) strb0_ff <= S_AXI_WSTRB[0];
   end
   // Shadow mode lands one edge after pairing, as the design's does; low strobe needed
   always_ff @(posedge CLK)
   begin
      pend_ff <= !RST && wr_done && cur_addr == TWS_OFF_MODE
         && (w_now ? S_AXI_WSTRB[0] : strb0_ff);
      pend_val_ff <= tws_mode_s'(w_now ? S_AXI_WDATA[3:0] : data_ff);
      if (RST) mode_ff <= TWS_MODE_RST;
      else if (pend_ff) mode_ff <= pend_val_ff;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   a_so_idle_high: assert property (!mode_ff.tx_enable_bit [*3] |-> SERIAL_OUT_PIN)
      else $error("serial out low while transmit off");
   a_clk_drive_sel: assert property (SHIFT_CLOCK_PIN_OE_N == !mode_ff.int_clk)
      else $error("clock drive does not follow mode");
   a_ext_clk_high: assert property (SHIFT_CLOCK_PIN_OE_N |-> SHIFT_CLOCK_PIN_O)
      else $error("clock output low in external mode");
   a_done_one_pulse: assert property (TRANSFER_DONE_IRQ |=> !TRANSFER_DONE_IRQ)
      else $error("done pulse longer than one cycle");
   a_clk_stops_high: assert property (TRANSFER_DONE_IRQ && !SHIFT_CLOCK_PIN_OE_N
      |-> SHIFT_CLOCK_PIN_O [*2])
      else $error("shift clock not high after byte");
   a_no_done_off: assert property (!(mode_ff.tx_enable_bit || mode_ff.rx_enable_bit) [*3]
      |-> !TRANSFER_DONE_IRQ)
      else $error("done pulse while both directions off");
   a_write_answer: assert property (wr_done |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   c_int_done: cover property (TRANSFER_DONE_IRQ && !SHIFT_CLOCK_PIN_OE_N);
   c_ext_done: cover property (TRANSFER_DONE_IRQ && SHIFT_CLOCK_PIN_OE_N);
   c_mode_wr: cover property (wr_done && cur_addr == TWS_OFF_MODE);
endmodule // tws_ctrl_monitor
bind tws_ctrl tws_ctrl_monitor mon_u (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .SHIFT_CLOCK_PIN_O(SHIFT_CLOCK_PIN_O), .SHIFT_CLOCK_PIN_OE_N(SHIFT_CLOCK_PIN_OE_N),
   .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .TRANSFER_DONE_IRQ(TRANSFER_DONE_IRQ));

// [testbench/tws_peer.sv]
// Clocked serial peripheral on the far side of the lines
`timescale 1ns/1ps
module tws_peer
(
   input wire logic sck_line,
   input wire logic so_line,
   output logic sck_ext,
   output logic si_line
);
   logic [7:0] tx_byte = 8'h00; // Byte sent to the device
   logic [7:0] rx_byte = 8'h00; // Bits seen, first one on top
   int rises = 0; // Clock rises since clear
   int falls = 0;
   initial sck_ext = 1'b1;
   initial si_line = 1'b0;
   // Take serial out on the rise, where it is settled
   always @(posedge sck_line)
   begin
      rx_byte = {rx_byte[6:0], so_line};
      rises = rises + 1;
   end
   // New bit on each fall; past the byte the line toggles so stale bits never match
   always @(negedge sck_line)
   begin
      if (falls < 8) si_line = tx_byte[7 - falls];
      else si_line = ~si_line;
      falls = falls + 1;
   end
   // Fresh byte to send, counters cleared
   task automatic clear(input logic [7:0] b);
      tx_byte = b;
      rises = 0;
      falls = 0;
   endtask
   // Clock runs only inside a frame, 160 ns period, low half first
   task automatic frame(input int n);
      repeat (n)
      begin
         sck_ext = 1'b0;
         #80;
         sck_ext = 1'b1;
         #80;
      end
   endtask
endmodule // tws_peer

// [testbench/tb_tws_ctrl.sv]
// Self-checking bench for the serial transfer control
`timescale 1ns/1ps
module tb_tws_ctrl;
   import tws_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [TWS_ADDR_W-1:0] awaddr;
   logic [TWS_ADDR_W-1:0] araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [3:0] strb = 4'h3; // Strobes for the next write
   logic awvalid;
   logic wvalid;
   logic bready;
   logic arvalid;
   logic rready;
   logic awready, wready, bvalid, arready, rvalid, sck_o, oe_n, so, irq, sck_ext, si, sck_line;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   int num_errors = 0;
   int compares = 0;
   int irq_cnt = 0; // Done pulses seen
   int n0;
   // Shared clock line: device drives it only when its enable is low
   assign sck_line = oe_n ? sck_ext : sck_o;
   always #4 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
   tws_ctrl dut_u (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SHIFT_CLOCK_PIN_I(sck_line), .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE_N(oe_n),
      .SERIAL_IN_PIN(si), .SERIAL_OUT_PIN(so), .TRANSFER_DONE_IRQ(irq));
   tws_peer peer_u (.sck_line(sck_line), .so_line(so), .sck_ext(sck_ext), .si_line(si));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Write: both halves offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic aw, w;
      @(posedge clk); // Let an edge pass after any earlier transfer
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= v;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (aw && awready === 1'b1) aw = 1'b0;
         if (w && wready === 1'b1) w = 1'b0;
         awvalid <= aw;
         wvalid <= w;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, TWS_RESP_OKAY);
   endtask
   // Read: low byte returned in d
   task automatic rd(input logic [3:0] a);
      logic ar;
      @(posedge clk); // Let an edge pass after any earlier transfer
      ar = 1'b1;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (ar && arready === 1'b1) ar = 1'b0;
         arvalid <= ar;
      end while (rvalid !== 1'b1);
      d = rdata & 32'hff;
      rready <= 1'b0;
      chk(rresp, TWS_RESP_OKAY);
   endtask
   // Unbounded here; the watchdog ends a hang
   task automatic wait_done;
      while (irq_cnt == n0) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_reset;
      chk(so, 1'b1);
      chk(sck_o, 1'b1);
      chk(oe_n, 1'b1);
      rd(TWS_OFF_DIV);
      chk(d, 32'h4);
      // Mode write without the low strobe must leave the mode alone
      strb = 4'h2;
      wr(TWS_OFF_MODE, 32'hf);
      strb = 4'h3;
      chk(oe_n, 1'b1);
      rd(TWS_OFF_MODE);
      chk(d, 32'h0);
   endtask
   // Internal clock, transmit only, MSB first; input still shifted in
   task automatic s_int_tx;
      peer_u.clear(8'hc3);
      wr(TWS_OFF_MODE, 32'h9);
      n0 = irq_cnt;
      wr(TWS_OFF_DATA, 32'ha5);
      wait_done;
      chk(peer_u.rx_byte, 8'ha5);
      chk(peer_u.rises, 8);
      chk(sck_o, 1'b1);
      rd(TWS_OFF_STAT);
      chk(d, 32'h2);
      rd(TWS_OFF_DATA);
      chk(d, 32'hc3);
   endtask
   // Order fixed at load, duplex started by receive enable rising
   task automatic s_duplex;
      wr(TWS_OFF_MODE, 32'hc);
      peer_u.clear(8'h00);
      wr(TWS_OFF_DATA, 32'h12);
      n0 = irq_cnt;
      wr(TWS_OFF_MODE, 32'hb);
      wait_done;
      chk(peer_u.rx_byte, 8'h48);
      chk(irq_cnt, n0 + 1);
      wr(TWS_OFF_MODE, 32'h8);
   endtask
   // Receive only: start on enable rise, then again on a read
   task automatic s_int_rx;
      peer_u.clear(8'h6d);
      n0 = irq_cnt;
      wr(TWS_OFF_MODE, 32'ha);
      wait_done;
      peer_u.clear(8'h3b);
      n0 = irq_cnt;
      rd(TWS_OFF_DATA);
      chk(d, 32'h6d);
      wait_done;
      chk(peer_u.rises, 8);
      wr(TWS_OFF_MODE, 32'h8);
      chk(so, 1'b1);
      rd(TWS_OFF_DATA);
      chk(d, 32'h3b);
   endtask
   // Transmit disabled mid-byte with internal clock
   task automatic s_int_abort;
      wr(TWS_OFF_MODE, 32'h9);
      peer_u.clear(8'h00);
      n0 = irq_cnt;
      wr(TWS_OFF_DATA, 32'h00);
      repeat (10) @(posedge clk); // Disable lands while the shift clock is low
      wr(TWS_OFF_MODE, 32'h8);
      repeat (60) @(posedge clk);
      chk(irq_cnt, n0);
      chk(so, 1'b1);
      chk(sck_o, 1'b1);
      chk(peer_u.rises, 2);
   endtask
   // External clock: early edges ignored, abort, counter restart
   task automatic s_ext_tx;
      logic s;
      wr(TWS_OFF_MODE, 32'h1);
      s = so;
      n0 = irq_cnt;
      peer_u.frame(8);
      repeat (6) @(posedge clk);
      chk(so, s);
      chk(irq_cnt, n0);
      peer_u.clear(8'h00);
      wr(TWS_OFF_DATA, 32'h96);
      peer_u.frame(8);
      wait_done;
      chk(peer_u.rx_byte, 8'h96);
      wr(TWS_OFF_DATA, 32'h0f);
      n0 = irq_cnt;
      peer_u.frame(3);
      wr(TWS_OFF_MODE, 32'h0);
      peer_u.frame(6);
      repeat (6) @(posedge clk);
      chk(so, 1'b1);
      chk(irq_cnt, n0);
      wr(TWS_OFF_MODE, 32'h1);
      peer_u.clear(8'h00);
      wr(TWS_OFF_DATA, 32'h5a);
      peer_u.frame(8);
      wait_done;
      chk(peer_u.rx_byte, 8'h5a);
      // Loaded inverted, so a peer behind an inverting buffer gets a5
      chk(8'(~peer_u.rx_byte), 8'ha5);
      chk(irq_cnt, n0 + 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} <= '0;
      {awaddr, araddr, wdata, wstrb} <= '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_reset;
      s_int_tx;
      s_duplex;
      s_int_rx;
      s_int_abort;
      s_ext_tx;
      end_sim;
   end
   // Watchdog at 50,000 cycles, far beyond the expected run of some 1,200 cycles
   initial
   begin
      #400000;
      num_errors++;
      end_sim;
   end
endmodule // tb_tws_ctrl
